// ===== verilog/sdram_pin_interface_addr_mux.sv
// sdram_pin_interface_addr_mux: pin side of the sdram controller
// assumes: sequencer on ref_clk drives row/col phase, strobes and masks;
// read strobes return on a 90-degree shifted link clock (strobe_clk).
`timescale 1ns/1ps
`default_nettype none

module sdram_pin_interface_addr_mux #(
    parameter int ROW_BITS0 = 12,
    parameter int ROW_BITS1 = 12,
    parameter int ROW_BITS2 = 12,
    parameter int ROW_BITS3 = 12,
    parameter int COL_BITS0 = 8,
    parameter int COL_BITS1 = 8,
    parameter int COL_BITS2 = 8,
    parameter int COL_BITS3 = 8,
    parameter logic [7:0] BASE0 = 8'h00,
    parameter logic [7:0] BASE1 = 8'h10,
    parameter logic [7:0] BASE2 = 8'h20,
    parameter logic [7:0] BASE3 = 8'h30,
    parameter logic [7:0] BASE_MASK = 8'hF0
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic strobe_clk,
    input wire logic ddr_mode,
    input wire logic module_enable,
    input wire logic [31:0] bus_addr,
    input wire logic [7:0] bus_base,
    input wire logic open_row,
    input wire logic issue_rw,
    input wire logic write_cycle,
    input wire logic load_mode,
    input wire logic [1:0] mode_select,
    input wire logic [12:0] mode_value,
    input wire logic clock_enable_req,
    input wire logic [3:0] write_lane_mask,
    input wire logic [31:0] write_data,
    input wire logic drive_data,
    input wire logic read_strobe_req,
    output logic [12:0] mem_addr_bus,
    output logic [1:0] bank_select,
    output logic [3:0] block_select_n,
    output logic [3:0] byte_write_mask,
    output logic mem_write_enable_n,
    output logic mem_clock_enable,
    output logic [1:0] mem_clock_out,
    output logic [1:0] mem_clock_out_n,
    output logic looped_read_strobe,
    input wire logic [31:0] mem_data_bus_in,
    output logic [31:0] mem_data_bus_out,
    output logic mem_data_bus_oe,
    input wire logic [3:0] data_strobe_lane_in,
    output logic [31:0] read_data,
    output logic read_valid,
    output logic block_hit
);

    // ------------------------------------------------------------
    // organization helpers
    // ------------------------------------------------------------
    function automatic logic [12:0] row_of(input logic [25:0] a, input int rb, input int cb);
        logic [12:0] r;
        r = {1'b0, a[21:10]};
        if (cb <= 8 && rb == 13)
            r[12] = a[22];
        else if (cb > 8)
            r[12] = 1'b0;
        return r;
    endfunction : row_of

    function automatic logic [12:0] col_of(input logic [25:0] a, input int cb);
        logic [12:0] c;
        c = {5'h00, a[7:0]};
        for (int i = 8; i < memif_pkg::COL_MAX; i++)
            if (i < cb)
                c[(i < 10) ? i : i + 1] = a[14 + i]; // skip A10 auto-precharge line
        return c;
    endfunction : col_of

    // widths beyond the supported organization are cut back here, so a bad
    // parameter set degrades to a legal map instead of aliasing address bits
    function automatic int fit_rows(input int rb);
        return (rb > memif_pkg::ROW_MAX) ? memif_pkg::ROW_MAX : rb;
    endfunction : fit_rows

    function automatic int fit_cols(input int rb, input int cb);
        int lim;
        lim = memif_pkg::ROWCOL_MAX - fit_rows(rb);
        if (lim > memif_pkg::COL_MAX)
            lim = memif_pkg::COL_MAX;
        return (cb > lim) ? lim : cb;
    endfunction : fit_cols

    localparam int ROWS [4] = '{fit_rows(ROW_BITS0), fit_rows(ROW_BITS1),
        fit_rows(ROW_BITS2), fit_rows(ROW_BITS3)};
    localparam int COLS [4] = '{fit_cols(ROW_BITS0, COL_BITS0), fit_cols(ROW_BITS1, COL_BITS1),
        fit_cols(ROW_BITS2, COL_BITS2), fit_cols(ROW_BITS3, COL_BITS3)};
    localparam logic [7:0] BASES [4] = '{BASE0, BASE1, BASE2, BASE3};

    // ------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------
    logic [25:0] held_addr;
    logic [3:0] hit;
    logic [1:0] blk;
    logic [1:0] next_blk;

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            held_addr <= '0;
        else if (module_enable)
            held_addr <= bus_addr[memif_pkg::ADDR_TOP:memif_pkg::COL_LO];

    // each block compares against its own base
    genvar g;
    generate
        for (g = 0; g < memif_pkg::BLOCKS; g++)
        begin : g_hit
            assign hit[g] = ((bus_base & BASE_MASK) == (BASES[g] & BASE_MASK));
        end
    endgenerate

    always_comb
    begin
        next_blk = 2'h0;
        for (int i = memif_pkg::BLOCKS - 1; i >= 0; i--)
            if (hit[i])
                next_blk = 2'(i);
    end

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            blk <= 2'h0;
        else if (module_enable)
            blk <= next_blk;

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            block_hit <= 1'b0;
        else if (module_enable)
            block_hit <= |hit;

    // ------------------------------------------------------------
    // command and address pins
    // ------------------------------------------------------------
    logic [12:0] row_word;
    logic [12:0] col_word;

    // widths fixed per block, limited to the supported maximum
    always_comb
    begin
        row_word = row_of(held_addr, ROWS[blk], COLS[blk]);
        col_word = col_of(held_addr, COLS[blk]);
    end

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
        begin
            mem_addr_bus <= '0;
            bank_select <= '0;
        end
        else if (load_mode)
        begin
            mem_addr_bus <= mode_value;
            bank_select <= mode_select;
        end
        else if (open_row)
        begin
            mem_addr_bus <= row_word;
            bank_select <= held_addr[9:8];
        end
        else if (issue_rw)
        begin
            mem_addr_bus <= col_word;
            bank_select <= held_addr[9:8];
        end

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            block_select_n <= memif_pkg::RST_SELECT_N;
        else if (load_mode)
            block_select_n <= 4'h0;
        else if (open_row || issue_rw)
            block_select_n <= ~(4'h1 << blk);
        else
            block_select_n <= memif_pkg::RST_SELECT_N;

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            mem_write_enable_n <= 1'b1;
        else
            mem_write_enable_n <= ~(issue_rw && write_cycle);

    // masks pass lane for lane; reads mask all in ddr, none in sdr
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            byte_write_mask <= memif_pkg::RST_MASK;
        else if (write_cycle)
            byte_write_mask <= write_lane_mask;
        else
            byte_write_mask <= {memif_pkg::LANES{ddr_mode}};

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            mem_clock_enable <= memif_pkg::RST_CKE;
        else
            mem_clock_enable <= clock_enable_req;

    // ------------------------------------------------------------
    // write data and clock forwarding
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            mem_data_bus_out <= '0;
        else
            mem_data_bus_out <= write_data;

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            mem_data_bus_oe <= 1'b0;
        else
            mem_data_bus_oe <= drive_data;

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            looped_read_strobe <= 1'b0;
        else
            looped_read_strobe <= read_strobe_req && !ddr_mode;

    // forwarded clock is the controller clock itself, gated off in reset
    assign mem_clock_out = {2{ref_clk & rstn}};
    assign mem_clock_out_n = ~mem_clock_out;

    // ------------------------------------------------------------
    // read capture on the strobe domain
    // ------------------------------------------------------------
    // strobe_clk is the returned strobe delayed a quarter period, so each
    // edge lands mid data window; sdr loops the read strobe into this path
    logic [1:0] link_rst_sync;
    logic [31:0] rise_word;
    logic [31:0] fall_word;
    logic rise_toggle;
    logic fall_toggle;
    logic [2:0] rise_sync;
    logic [2:0] fall_sync;

    always_ff @(posedge strobe_clk or negedge rstn)
        if (!rstn)
            link_rst_sync <= 2'b00;
        else
            link_rst_sync <= {link_rst_sync[0], 1'b1};

    // mode level comes from the controller clock; resynchronised before the
    // strobe side reads it, so a mode change cannot half-enable fall capture
    logic [1:0] ddr_sync;

    always_ff @(posedge strobe_clk or negedge rstn)
        if (!rstn)
            ddr_sync <= 2'b00;
        else
            ddr_sync <= {ddr_sync[0], ddr_mode};

    // lane n is sampled by its own strobe; lane 3 carries bits 31:24
    generate
        for (g = 0; g < memif_pkg::LANES; g++)
        begin : g_lane
            always_ff @(posedge strobe_clk or negedge rstn)
                if (!rstn)
                    rise_word[8*g+:8] <= 8'h00;
                else if (data_strobe_lane_in[g])
                    rise_word[8*g+:8] <= mem_data_bus_in[8*g+:8];

            always_ff @(negedge strobe_clk or negedge rstn)
                if (!rstn)
                    fall_word[8*g+:8] <= 8'h00;
                else if (data_strobe_lane_in[g])
                    fall_word[8*g+:8] <= mem_data_bus_in[8*g+:8];
        end
    endgenerate

    always_ff @(posedge strobe_clk or negedge rstn)
        if (!rstn)
            rise_toggle <= 1'b0;
        else if (link_rst_sync[1] && |data_strobe_lane_in)
            rise_toggle <= ~rise_toggle;

    always_ff @(negedge strobe_clk or negedge rstn)
        if (!rstn)
            fall_toggle <= 1'b0;
        else if (link_rst_sync[1] && |data_strobe_lane_in && ddr_sync[1])
            fall_toggle <= ~fall_toggle;

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
        begin
            rise_sync <= 3'h0;
            fall_sync <= 3'h0;
        end
        else
        begin
            rise_sync <= {rise_sync[1:0], rise_toggle};
            fall_sync <= {fall_sync[1:0], fall_toggle};
        end

    // captured word is stable for many ref_clk cycles once its toggle lands
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            read_data <= '0;
        else if (rise_sync[2] != rise_sync[1])
            read_data <= rise_word;
        else if (fall_sync[2] != fall_sync[1])
            read_data <= fall_word;

    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            read_valid <= 1'b0;
        else
            read_valid <= (rise_sync[2] != rise_sync[1]) || (fall_sync[2] != fall_sync[1]);

endmodule : sdram_pin_interface_addr_mux
`default_nettype wire

// ===== inc/memif_pkg.sv
// memif_pkg: constants for the sdram pin interface and address multiplexer
// assumes: included before the design file, nothing imported
package memif_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;
    localparam int BLOCKS = 4;
    localparam int LANES = 4;
    localparam int ROW_MAX = 13;
    localparam int COL_MAX = 12;
    localparam int ROWCOL_MAX = 24;

    // ------------------------------------------------------------
    // internal address field positions
    // ------------------------------------------------------------
    localparam int COL_LO = 2;
    localparam int BANK_LO = 10;
    localparam int ROW_LO = 12;
    localparam int EXTRA_LO = 24;
    localparam int ADDR_TOP = 27;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_CKE = 1'b0;
    localparam logic [3:0] RST_SELECT_N = 4'hF;
    localparam logic [3:0] RST_MASK = 4'hF;

    // ------------------------------------------------------------
    // address phase encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ROW = 2'b01,
        PH_COL = 2'b11
    } phase_t;

endpackage : memif_pkg

// ===== tb/pin_checker.sv
// pin_checker: timing relations at the pins of the address multiplexer
// assumes: bound onto the design top, one clock domain, sees ports only
`timescale 1ns/1ps
`default_nettype none
module pin_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic module_enable,
    input wire logic [31:0] bus_addr,
    input wire logic open_row,
    input wire logic issue_rw,
    input wire logic load_mode,
    input wire logic write_cycle,
    input wire logic [1:0] mode_select,
    input wire logic [12:0] mode_value,
    input wire logic clock_enable_req,
    input wire logic [3:0] write_lane_mask,
    input wire logic [12:0] mem_addr_bus,
    input wire logic [1:0] bank_select,
    input wire logic [3:0] block_select_n,
    input wire logic [3:0] byte_write_mask,
    input wire logic mem_write_enable_n,
    input wire logic mem_clock_enable,
    input wire logic [1:0] mem_clock_out,
    input wire logic [1:0] mem_clock_out_n,
    input wire logic read_valid
);
    // ----------
    // assertions
    // ----------
    logic [31:0] held;
    logic row_cmd;
    logic col_cmd;
    assign row_cmd = open_row && !load_mode;
    assign col_cmd = issue_rw && !open_row && !load_mode;
    // own copy of the latched address, so row and column see their source
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            held <= '0;
        else if (module_enable)
            held <= bus_addr;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    a_row_addr: assert property (row_cmd |=> mem_addr_bus[11:0] == held[23:12])
        else $error("row address wrong");
    a_col_addr: assert property (col_cmd |=> mem_addr_bus[7:0] == held[9:2])
        else $error("column address wrong");
    a_bank_map: assert property ((row_cmd || col_cmd) |=> bank_select == held[11:10])
        else $error("bank select wrong");
    a_mode_load: assert property (load_mode |=> mem_addr_bus == $past(mode_value) && bank_select == $past(mode_select))
        else $error("mode load value wrong");
    a_write_strobe: assert property (col_cmd |=> mem_write_enable_n == !$past(write_cycle))
        else $error("write enable wrong");
    a_write_mask: assert property (col_cmd && write_cycle |=> byte_write_mask == $past(write_lane_mask))
        else $error("write mask wrong");
    a_select_idle: assert property (!(open_row || issue_rw || load_mode) |=> block_select_n == 4'hF)
        else $error("block select without command");
    a_one_block: assert property (!$past(load_mode) |-> $onehot0(~block_select_n))
        else $error("two blocks selected");
    a_mode_selects: assert property (load_mode |=> block_select_n == 4'h0)
        else $error("mode load misses a block");
    a_clock_pair: assert property (mem_clock_out == ~mem_clock_out_n)
        else $error("clock pair not inverse");
    a_self_refresh: assert property (!clock_enable_req [*2] |=> !mem_clock_enable)
        else $error("clock enable stays high");
    a_valid_pulse: assert property (read_valid |=> !read_valid)
        else $error("read valid longer than a cycle");
endmodule : pin_checker
`default_nettype wire

// ===== tb/mem_model.sv
// mem_model: behavioural sdram devices behind the pins
// assumes: read_go marks a column read, since no command strobes reach here
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic ref_clk,
    input wire logic strobe_clk,
    input wire logic ddr_mode,
    input wire logic fall_edge,
    input wire logic read_go,
    input wire logic [3:0] block_select_n,
    input wire logic [12:0] mem_addr_bus,
    input wire logic [3:0] byte_write_mask,
    input wire logic [31:0] mem_data_bus_out,
    input wire logic mem_data_bus_oe,
    input wire logic looped_read_strobe,
    output logic [31:0] mem_data_bus_in,
    output logic [3:0] data_strobe_lane_in
);
    // -------
    // storage
    // -------
    logic [31:0] mem [256];
    logic [31:0] word;
    logic [7:0] col;
    logic [3:0] dqs;
    initial
    begin
        foreach (mem[i]) mem[i] = '0;
        col = '0;
        dqs = '0;
        word = '1;
    end
    always @(posedge ref_clk)
    begin
        if (block_select_n != 4'hF) col <= mem_addr_bus[7:0];
        for (int b = 0; b < 4; b++)
            if (mem_data_bus_oe && !byte_write_mask[b]) mem[col][8*b +: 8] <= mem_data_bus_out[8*b +: 8];
    end
    // strobe high over one edge only; data flips with the strobe edges
    always @(posedge read_go)
    begin
        if (fall_edge) @(posedge strobe_clk);
        else @(negedge strobe_clk);
        #20;
        word = mem[col];
        dqs = 4'hF;
        #40;
        word = ~mem[col];
        dqs = 4'h0;
    end
    // released sdr bus shows the live inverse of the word; ddr shows the held copy in word
    assign mem_data_bus_in = ddr_mode ? word : (looped_read_strobe ? mem[col] : ~mem[col]);
    assign data_strobe_lane_in = ddr_mode ? dqs : {4{looped_read_strobe}};
endmodule : mem_model
`default_nettype wire

// ===== tb/testbench.sv
// testbench: drives the pin interface against the memory model
// assumes: package, design, checker and model compiled before this file
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, strobe_clk, rstn, ddr_mode, module_enable, open_row, issue_rw, write_cycle, load_mode;
    logic clock_enable_req, drive_data, read_strobe_req, fall_edge, read_go, mem_write_enable_n, mem_clock_enable;
    logic looped_read_strobe, mem_data_bus_oe, read_valid, block_hit;
    logic [31:0] bus_addr, write_data, mem_data_bus_in, mem_data_bus_out, read_data;
    logic [12:0] mode_value, mem_addr_bus;
    logic [7:0] bus_base;
    logic [3:0] write_lane_mask, block_select_n, byte_write_mask, data_strobe_lane_in;
    logic [1:0] mode_select, bank_select, mem_clock_out, mem_clock_out_n;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    // block 3 uses 13 row bits so the extra row line is exercised
    sdram_pin_interface_addr_mux #(.ROW_BITS3(13)) i_sdram_pin_interface_addr_mux (.ref_clk, .rstn, .strobe_clk, .ddr_mode,
        .module_enable, .bus_addr, .bus_base, .open_row, .issue_rw, .write_cycle, .load_mode, .mode_select,
        .mode_value, .clock_enable_req, .write_lane_mask, .write_data, .drive_data, .read_strobe_req,
        .mem_addr_bus, .bank_select, .block_select_n, .byte_write_mask, .mem_write_enable_n, .mem_clock_enable,
        .mem_clock_out, .mem_clock_out_n, .looped_read_strobe, .mem_data_bus_in, .mem_data_bus_out,
        .mem_data_bus_oe, .data_strobe_lane_in, .read_data, .read_valid, .block_hit);
    mem_model i_mem_model (.ref_clk, .strobe_clk, .ddr_mode, .fall_edge, .read_go, .block_select_n, .mem_addr_bus,
        .byte_write_mask, .mem_data_bus_out, .mem_data_bus_oe, .looped_read_strobe, .mem_data_bus_in,
        .data_strobe_lane_in);
    // ---------
    // scenarios
    // ---------
    initial
    begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    // strobe clock is a free-running 80 ns clock offset by 7 ns, which never stops
    initial
    begin
        strobe_clk = 0;
        #7;
        forever #40 strobe_clk = ~strobe_clk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    task automatic access(input logic [1:0] blk, input logic [31:0] a, input logic wr, input logic [3:0] m);
        logic [3:0] sel;
        sel = ~(4'h1 << blk);
        bus_addr = a;
        bus_base = {2'b00, blk, 4'h0};
        module_enable = 1;
        step(1);
        chk("hit", 1'b1, block_hit);
        module_enable = 0;
        open_row = 1;
        step(1);
        open_row = 0;
        chk("row", a[23:12], mem_addr_bus[11:0]);
        chk("select", sel, block_select_n);
        chk("bank", a[11:10], bank_select);
        chk("row12", (blk == 2'd3) ? a[24] : 1'b0, mem_addr_bus[12]);
        write_cycle = wr;
        write_lane_mask = m;
        issue_rw = 1;
        step(1);
        issue_rw = 0;
        chk("col", a[9:2], mem_addr_bus[7:0]);
        chk("we", !wr, mem_write_enable_n);
        chk("mask", wr ? m : {4{ddr_mode}}, byte_write_mask);
    endtask : access
    task automatic write_word(input logic [1:0] blk, input logic [31:0] a, input logic [31:0] d, input logic [3:0] m);
        access(blk, a, 1'b1, m);
        step(1);
        write_data = d;
        drive_data = 1;
        step(1);
        drive_data = 0;
        step(2);
        write_cycle = 0;
    endtask : write_word
    task automatic read_word(input logic [1:0] blk, input logic [31:0] a, input logic ddr, input logic f,
        input logic [31:0] exp);
        int n;
        ddr_mode = ddr;
        fall_edge = f;
        access(blk, a, 1'b0, 4'h0);
        read_go = ddr;
        read_strobe_req = !ddr;
        step(2);
        read_go = 0;
        read_strobe_req = 0;
        n = 0;
        while (read_valid !== 1'b1 && n < 40)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("valid", 1'b1, read_valid);
        chk("read", exp, read_data);
        chk("clk", 4'hF, {mem_clock_out, ~mem_clock_out_n});
        step(6);
    endtask : read_word
    initial
    begin
        {rstn, ddr_mode, module_enable, open_row, issue_rw, write_cycle, load_mode} = '0;
        {clock_enable_req, drive_data, read_strobe_req, fall_edge, read_go} = '0;
        {bus_addr, write_data, mode_value, bus_base, write_lane_mask, mode_select} = '0;
        step(3);
        chk("rst_cke", 1'b0, mem_clock_enable);
        chk("rst_sel", 4'hF, block_select_n);
        rstn = 1;
        mode_value = 13'h0033;
        load_mode = 1;
        step(1);
        load_mode = 0;
        chk("mode", 13'h0033, mem_addr_bus);
        clock_enable_req = 1;
        step(3);
        chk("cke_on", 1'b1, mem_clock_enable);
        write_word(2'd1, 32'h00ABC5F4, 32'h11223344, 4'b0101);
        read_word(2'd1, 32'h00ABC5F4, 1'b0, 1'b0, 32'h11003300);
        write_word(2'd3, 32'h01FFFFFC, 32'hA5C3E187, 4'b0000);
        read_word(2'd3, 32'h01FFFFFC, 1'b1, 1'b0, 32'hA5C3E187);
        read_word(2'd3, 32'h01FFFFFC, 1'b1, 1'b1, 32'hA5C3E187);
        clock_enable_req = 0;
        step(3);
        chk("cke_off", 1'b0, mem_clock_enable);
        end_sim();
    end
endmodule : testbench
bind sdram_pin_interface_addr_mux pin_checker i_pin_checker (.ref_clk, .rstn, .module_enable, .bus_addr,
    .open_row, .issue_rw, .load_mode, .write_cycle, .mode_select, .mode_value, .clock_enable_req,
    .write_lane_mask, .mem_addr_bus, .bank_select, .block_select_n, .byte_write_mask, .mem_write_enable_n,
    .mem_clock_enable, .mem_clock_out, .mem_clock_out_n, .read_valid);
`default_nettype wire
